// file: rtl/vdr_map.vh
`ifndef VDR_MAP_VH
`define VDR_MAP_VH

// Register offsets on the command link
`define VDR_OFS_MARGIN     8'h83
`define VDR_OFS_SELFTEST   8'h85
`define VDR_OFS_ACCESS     8'h86
`define VDR_OFS_OVERRIDE   8'ha0
`define VDR_OFS_SIGNATURE  8'ha1
`define VDR_OFS_FAULTS     8'ha3
`define VDR_OFS_TEMPANGLE  8'ha7
`define VDR_OFS_CHAN_FINAL 8'ha8
`define VDR_OFS_CHAN_PRE   8'ha9
`define VDR_OFS_RADIUS     8'haa

// Margin control fields
`define VDR_MRG_REPEAT     13
`define VDR_MRG_PTR_HI     12
`define VDR_MRG_PTR_LO     7
`define VDR_MRG_ORIGIN     6
`define VDR_MRG_LIMIT      5
`define VDR_MRG_STATE_HI   4
`define VDR_MRG_STATE_LO   3
`define VDR_MRG_LOWER_SKIP 2
`define VDR_MRG_UPPER_SKIP 1
`define VDR_MRG_GO         0

// Margin state codes
`define VDR_MST_NONE       2'h0
`define VDR_MST_PASS       2'h1
`define VDR_MST_FAIL       2'h2
`define VDR_MST_RUN        2'h3

// Other fields
`define VDR_ST_OUTCOME     5
`define VDR_ST_DONE        4
`define VDR_ACC_GRANTED    1
`define VDR_OVR_MANCH      7
`define VDR_OVR_LAUNCH     0
`define VDR_FLT_RADIUS     5
`define VDR_FLT_WIDTH      13
`define VDR_RADIUS_WIDTH   17

// Reset values
`define VDR_RST_PTR        6'h00
`define VDR_RST_WORD       32'h0000_0000

`endif

// file: rtl/vdr_diag_regs.v
`timescale 1ns/10ps
`include "vdr_map.vh"

////////////////////////////////////////////////////////////////////////////////
module vdr_diag_regs #(
  parameter [5:0]  MARGIN_LAST  = 6'h3f,         // Highest word checked
  parameter [31:0] SIG_EXPECTED = 32'h0000_0000, // Expected signature
  parameter [16:0] RADIUS_MIN   = 17'h00400,     // Radius squared floor
  parameter [16:0] RADIUS_MAX   = 17'h1fc00      // Radius squared ceiling
) (
  input  wire        sys_clk,         // System clock, 100 MHz
  input  wire        rst_n,           // Synchronous reset, active low
  input  wire [7:0]  reg_addr,        // Decoded register address
  input  wire [31:0] reg_wdata,       // Write data
  input  wire        reg_wr,          // Write strobe, one cycle
  input  wire        reg_rd,          // Read strobe, one cycle
  output reg  [31:0] reg_rdata,       // Read data
  output reg         reg_rvalid,      // Read answer, one cycle
  output reg         mt_req,          // Margin check request
  output reg  [5:0]  mt_addr,         // Word under margin check
  output reg         mt_upper,        // Limit under check, 1 = upper
  input  wire        mt_ack,          // Margin check finished
  input  wire        mt_fail,         // Margin check failed, with ack
  output reg         selftest_launch, // Self-test start pulse
  input  wire        selftest_end,    // Self-test completion pulse
  input  wire [31:0] selftest_sig,    // Computed self-test signature
  input  wire        access_code_ok,  // Correct access code seen
  output reg         out_hiz,         // Output pin released
  output reg         manch_active,    // Command interface forced on
  input  wire [12:0] fault_raw,       // Raw fault conditions
  input  wire [12:0] fault_mask,      // Fault masks, 1 = masked
  input  wire [15:0] thermal_reading, // Temperature, 128 per degree
  input  wire [15:0] angle_reading,   // Angle, fraction of a turn
  input  wire [15:0] first_channel_final,      // Channel A final
  input  wire [15:0] second_channel_final,     // Channel B final
  input  wire [15:0] first_channel_prefilter,  // Channel A prefilter
  input  wire [15:0] second_channel_prefilter, // Channel B prefilter
  input  wire [16:0] radius_squared_value,     // Squared radius
  output reg         radius_fault     // Radius out of range
);

  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_CHECK = 2'h1;

  // Pointer field of a written margin word
  function [5:0] ptr_field;
    input [31:0] w;
    begin
      ptr_field = w[`VDR_MRG_PTR_HI:`VDR_MRG_PTR_LO];
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `VDR_OFS_MARGIN, `VDR_OFS_SELFTEST, `VDR_OFS_ACCESS,
        `VDR_OFS_OVERRIDE, `VDR_OFS_SIGNATURE, `VDR_OFS_FAULTS,
        `VDR_OFS_TEMPANGLE, `VDR_OFS_CHAN_FINAL, `VDR_OFS_CHAN_PRE,
        `VDR_OFS_RADIUS: is_mapped = 1'b1;
        default:        is_mapped = 1'b0;
      endcase
    end
  endfunction

  reg  [1:0]  state_reg;
  reg         margin_repeat_single;
  reg  [5:0]  margin_word_pointer;
  reg         margin_custom_origin;
  reg         margin_failed_limit;
  reg  [1:0]  margin_state;
  reg         margin_lower_skip;
  reg         margin_upper_skip;
  reg         margin_go;
  reg         fail_seen_reg;
  reg         st_done_reg;
  reg         st_pass_reg;
  reg  [31:0] st_sig_reg;
  reg         granted_reg;
  reg         manch_reg;
  reg  [12:0] fault_reg;
  wire [12:0] fault_cond;
  wire        wr_margin;
  wire        wr_override;
  wire        phase_skip;
  wire        step_done;
  wire        step_fail;
  wire        last_word;
  reg  [31:0] rd_word;

  assign wr_margin   = reg_wr && (reg_addr == `VDR_OFS_MARGIN);
  assign wr_override = reg_wr && (reg_addr == `VDR_OFS_OVERRIDE);
  assign phase_skip  = mt_upper ? margin_upper_skip : margin_lower_skip;
  // A raised request waits for its ack even if a skip bit is rewritten
  // mid-run; the new skip setting then acts from the next phase on
  assign step_done   = mt_req ? mt_ack : phase_skip;
  assign step_fail   = mt_req && mt_ack && mt_fail;
  assign last_word   = margin_repeat_single || (mt_addr == MARGIN_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Margin control fields written by software
  // Control bits may change mid-run; skip and repeat steer the phases still to come
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      margin_repeat_single <= 1'b0;
      margin_custom_origin <= 1'b0;
      margin_lower_skip    <= 1'b0;
      margin_upper_skip    <= 1'b0;
    end else if (wr_margin) begin
      margin_repeat_single <= reg_wdata[`VDR_MRG_REPEAT];
      margin_custom_origin <= reg_wdata[`VDR_MRG_ORIGIN];
      margin_lower_skip    <= reg_wdata[`VDR_MRG_LOWER_SKIP];
      margin_upper_skip    <= reg_wdata[`VDR_MRG_UPPER_SKIP];
    end
  end

  // A failure capture wins over a software write in the same cycle
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      margin_word_pointer <= `VDR_RST_PTR;
    end else if (state_reg == S_CHECK && step_fail) begin
      margin_word_pointer <= mt_addr;
    end else if (wr_margin && reg_wdata[`VDR_MRG_ORIGIN]) begin
      margin_word_pointer <= ptr_field(reg_wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Margin run sequencer
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg           <= S_IDLE;
      margin_go           <= 1'b0;
      margin_state        <= `VDR_MST_NONE;
      margin_failed_limit <= 1'b0;
      fail_seen_reg       <= 1'b0;
      mt_req              <= 1'b0;
      mt_addr             <= 6'h00;
      mt_upper            <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          mt_req <= 1'b0;
          if (wr_margin) begin
            margin_go <= reg_wdata[`VDR_MRG_GO];
          end
          if (wr_margin && reg_wdata[`VDR_MRG_GO]) begin
            state_reg     <= S_CHECK;
            margin_state  <= `VDR_MST_RUN;
            fail_seen_reg <= 1'b0;
            mt_upper      <= 1'b0;
            if (reg_wdata[`VDR_MRG_ORIGIN]) begin
              mt_addr <= ptr_field(reg_wdata);
            end else begin
              mt_addr <= 6'h00;
            end
          end
        end
        S_CHECK: begin
          if (wr_margin && !reg_wdata[`VDR_MRG_GO]) begin
            // Abort: partial coverage must never read as a pass
            state_reg    <= S_IDLE;
            margin_go    <= 1'b0;
            mt_req       <= 1'b0;
            margin_state <= fail_seen_reg ? `VDR_MST_FAIL : `VDR_MST_NONE;
          end else if (step_done) begin
            mt_req <= 1'b0;
            if (step_fail) begin
              fail_seen_reg       <= 1'b1;
              margin_failed_limit <= mt_upper;
            end
            if (!mt_upper) begin
              mt_upper <= 1'b1;
            end else begin
              mt_upper <= 1'b0;
              if (margin_repeat_single) begin
                // Repeat never ends on its own; clearing go ends it, or clearing repeat lets it run on to MARGIN_LAST
                mt_addr <= mt_addr;
              end else if (last_word) begin
                state_reg <= S_IDLE;
                margin_go <= 1'b0;
                if (fail_seen_reg || step_fail) begin
                  margin_state <= `VDR_MST_FAIL;
                end else begin
                  margin_state <= `VDR_MST_PASS;
                end
              end else begin
                mt_addr <= mt_addr + 6'h01;
              end
            end
          end else if (!mt_req) begin
            mt_req <= 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          margin_go <= 1'b0;
          mt_req    <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-test, access and override
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      st_done_reg     <= 1'b0;
      st_pass_reg     <= 1'b0;
      st_sig_reg      <= `VDR_RST_WORD;
      selftest_launch <= 1'b0;
    end else begin
      selftest_launch <= wr_override && reg_wdata[`VDR_OVR_LAUNCH];
      // A launch hides the old outcome until the new end pulse
      if (wr_override && reg_wdata[`VDR_OVR_LAUNCH]) begin
        st_done_reg <= 1'b0;
      end
      if (selftest_end) begin
        // Signature compare decides the outcome inside the block
        st_done_reg <= 1'b1;
        st_sig_reg  <= selftest_sig;
        st_pass_reg <= (selftest_sig == SIG_EXPECTED);
      end
    end
  end

  // Granted stays set until reset; the code cannot be withdrawn
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      granted_reg <= 1'b0;
    end else if (access_code_ok) begin
      granted_reg <= 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      manch_reg    <= 1'b0;
      out_hiz      <= 1'b0;
      manch_active <= 1'b0;
    end else begin
      if (wr_override) begin
        manch_reg <= reg_wdata[`VDR_OVR_MANCH];
      end
      // Pin release lags the write by two cycles, link enable with it
      out_hiz      <= manch_reg;
      manch_active <= manch_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags with masking; radius fault judged here from the square
  // Flags follow the live condition; nothing here latches a fault

  genvar gi;
  generate
    for (gi = 0; gi < `VDR_FLT_WIDTH; gi = gi + 1) begin : g_flt
      if (gi != `VDR_FLT_RADIUS) begin : g_raw
        assign fault_cond[gi] = fault_raw[gi];
      end else begin : g_rad
        assign fault_cond[gi] = radius_fault;
      end
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          fault_reg[gi] <= 1'b0;
        end else begin
          fault_reg[gi] <= fault_cond[gi] && !fault_mask[gi];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      radius_fault <= 1'b0;
    end else begin
      // Bounds are inclusive: a square equal to a bound is in range
      radius_fault <= (radius_squared_value < RADIUS_MIN) ||
                      (radius_squared_value > RADIUS_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses get no answer at all
  // Unlabelled bits read as zero
  always @* begin
    rd_word = `VDR_RST_WORD;
    case (reg_addr)
      `VDR_OFS_MARGIN: begin
        rd_word[`VDR_MRG_REPEAT]                   = margin_repeat_single;
        rd_word[`VDR_MRG_PTR_HI:`VDR_MRG_PTR_LO]   = margin_word_pointer;
        rd_word[`VDR_MRG_ORIGIN]                   = margin_custom_origin;
        rd_word[`VDR_MRG_LIMIT]                    = margin_failed_limit;
        rd_word[`VDR_MRG_STATE_HI:`VDR_MRG_STATE_LO] = margin_state;
        rd_word[`VDR_MRG_LOWER_SKIP]               = margin_lower_skip;
        rd_word[`VDR_MRG_UPPER_SKIP]               = margin_upper_skip;
        rd_word[`VDR_MRG_GO]                       = margin_go;
      end
      `VDR_OFS_SELFTEST: begin
        // Outcome shows only once done is set, so a stale pass never leaks
        rd_word[`VDR_ST_OUTCOME] = st_done_reg && st_pass_reg;
        rd_word[`VDR_ST_DONE]    = st_done_reg;
      end
      `VDR_OFS_ACCESS: begin
        rd_word[`VDR_ACC_GRANTED] = granted_reg;
      end
      `VDR_OFS_OVERRIDE: begin
        rd_word[`VDR_OVR_MANCH] = manch_reg;
      end
      `VDR_OFS_SIGNATURE: begin
        rd_word = st_sig_reg;
      end
      `VDR_OFS_FAULTS: begin
        rd_word[`VDR_FLT_WIDTH-1:0] = fault_reg;
      end
      `VDR_OFS_TEMPANGLE: begin
        rd_word = {thermal_reading, angle_reading};
      end
      `VDR_OFS_CHAN_FINAL: begin
        rd_word = {second_channel_final, first_channel_final};
      end
      `VDR_OFS_CHAN_PRE: begin
        rd_word = {second_channel_prefilter, first_channel_prefilter};
      end
      `VDR_OFS_RADIUS: begin
        rd_word[`VDR_RADIUS_WIDTH-1:0] = radius_squared_value;
      end
      default: begin
        rd_word = `VDR_RST_WORD;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata  <= `VDR_RST_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      // Read data holds until the next mapped read; an unanswered
      // read leaves the old word in place
      reg_rvalid <= reg_rd && is_mapped(reg_addr);
      if (reg_rd && is_mapped(reg_addr)) begin
        reg_rdata <= rd_word;
      end
    end
  end

endmodule

// file: bench/vdr_mem_model.sv
`timescale 1ns/10ps
module vdr_mem_model (
  input  wire       sys_clk,   // Clock
  input  wire       rst_n,     // Reset
  input  wire       mt_req,    // Check request
  input  wire [5:0] mt_addr,   // Word
  input  wire       mt_upper,  // Limit
  input  wire [3:0] slow,      // Extra wait cycles
  input  wire       bad_en,    // Failures on
  input  wire [5:0] bad_addr,  // Lowest failing word
  input  wire       bad_upper, // Failing limit
  output reg        mt_ack,    // Check done
  output reg        mt_fail    // Check failed
);
  reg [3:0] wait_reg;
  // Fail means nothing without ack, so it toggles to expose early sampling
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_reg <= 4'h0;
      mt_ack   <= 1'b0;
      mt_fail  <= 1'b0;
    end else if (!mt_req || mt_ack || wait_reg != slow) begin
      wait_reg <= (mt_req && !mt_ack) ? wait_reg + 4'h1 : 4'h0;
      mt_ack   <= 1'b0;
      mt_fail  <= ~mt_fail;
    end else begin
      mt_ack   <= 1'b1;
      mt_fail  <= bad_en && mt_addr >= bad_addr && mt_upper == bad_upper;
    end
  end
endmodule

// file: bench/vdr_diag_regs_checker.sv
`timescale 1ns/10ps
module vdr_diag_checker #(
  parameter [16:0] RADIUS_MIN = 17'h00400, // Radius floor
  parameter [16:0] RADIUS_MAX = 17'h1fc00  // Radius ceiling
) (
  input wire        sys_clk,              // Clock
  input wire        rst_n,                // Reset
  input wire [7:0]  reg_addr,             // Address
  input wire [31:0] reg_wdata,            // Write data
  input wire        reg_wr,               // Write
  input wire        reg_rd,               // Read
  input wire [31:0] reg_rdata,            // Read data
  input wire        mt_req,               // Check request
  input wire [5:0]  mt_addr,              // Word
  input wire        mt_upper,             // Limit
  input wire        mt_ack,               // Check done
  input wire        selftest_launch,      // Launch
  input wire        out_hiz,              // Pin released
  input wire        manch_active,         // Link forced
  input wire [12:0] fault_mask,           // Masks
  input wire [15:0] thermal_reading,      // Temperature
  input wire [15:0] angle_reading,        // Angle
  input wire [16:0] radius_squared_value, // Radius squared
  input wire        radius_fault          // Radius flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire mrg_wr = reg_wr && reg_addr == 8'h83;
  sequence s_acked; mt_req && mt_ack; endsequence
  sequence s_waiting; mt_req && !mt_ack && !(mrg_wr && !reg_wdata[0]); endsequence
  a_masked_flags_low: assert property (reg_rd && reg_addr == 8'ha3 |=>
    (reg_rdata[12:0] & $past(fault_mask, 2)) == 13'h0000)
    else $error("masked fault flag seen set");
  a_temp_angle_word: assert property (reg_rd && reg_addr == 8'ha7 |=>
    reg_rdata == {$past(thermal_reading), $past(angle_reading)})
    else $error("temperature and angle word misplaced");
  a_req_holds: assert property (s_waiting |=>
    mt_req && $stable(mt_addr) && $stable(mt_upper))
    else $error("check request changed before ack");
  a_req_gap: assert property (s_acked |=> !mt_req)
    else $error("check request not dropped after ack");
  a_abort_stops: assert property (mt_req && mrg_wr && !reg_wdata[0] |=> !mt_req)
    else $error("cleared start did not stop the run");
  a_override_follows: assert property (reg_wr && reg_addr == 8'ha0 |=> ##1
    out_hiz == $past(reg_wdata[7], 2) && manch_active == out_hiz)
    else $error("override outputs wrong");
  a_launch_pulse: assert property (reg_wr && reg_addr == 8'ha0 && reg_wdata[0] |=>
    selftest_launch ##1 !selftest_launch)
    else $error("self-test launch not a single pulse");
  a_radius_flag: assert property ($past(rst_n) |-> radius_fault ==
    ($past(radius_squared_value) < RADIUS_MIN || $past(radius_squared_value) > RADIUS_MAX))
    else $error("radius flag disagrees with radius");
endmodule

bind vdr_diag_regs vdr_diag_checker #(.RADIUS_MIN(RADIUS_MIN), .RADIUS_MAX(RADIUS_MAX)) u_chk (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mt_req, .mt_addr,
  .mt_upper, .mt_ack, .selftest_launch, .out_hiz, .manch_active, .fault_mask,
  .thermal_reading, .angle_reading, .radius_squared_value, .radius_fault);

// file: bench/test_volatile_diagnostic_registers.sv
`timescale 1ns/10ps
module test_volatile_diagnostic_registers;
  localparam [31:0] SIG_OK = 32'h5a5a_0f0f; // Arbitrary expected signature
  reg         sys_clk, rst_n, reg_wr, reg_rd, selftest_end, access_code_ok, bad_en, bad_upper;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata, selftest_sig, d;
  reg  [12:0] fault_raw, fault_mask;
  reg  [16:0] rsq;
  reg  [5:0]  bad_addr;
  reg  [3:0]  slow;
  reg  [15:0] temp_in, angle_in;
  reg  [5:0]  log_a [0:63];
  reg         log_u [0:63];
  wire [31:0] reg_rdata;
  wire [5:0]  mt_addr;
  wire        reg_rvalid, mt_req, mt_upper, mt_ack, mt_fail, selftest_launch;
  wire        out_hiz, manch_active, radius_fault;
  integer     failures, cmp_count, n_ack, i;

  vdr_diag_regs #(.MARGIN_LAST(6'h03), .SIG_EXPECTED(SIG_OK)) u_dut (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .mt_req, .mt_addr, .mt_upper, .mt_ack, .mt_fail, .selftest_launch, .selftest_end,
    .selftest_sig, .access_code_ok, .out_hiz, .manch_active, .fault_raw, .fault_mask,
    .thermal_reading(temp_in), .angle_reading(angle_in), .first_channel_final(16'h1234),
    .second_channel_final(16'h8765), .first_channel_prefilter(16'h0f0f),
    .second_channel_prefilter(16'hf0f0), .radius_squared_value(rsq), .radius_fault);
  vdr_mem_model u_mem (.sys_clk, .rst_n, .mt_req, .mt_addr, .mt_upper, .slow, .bad_en,
    .bad_addr, .bad_upper, .mt_ack, .mt_fail);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (mt_req && mt_ack && n_ack < 64) begin
      log_a[n_ack] <= mt_addr;
      log_u[n_ack] <= mt_upper;
      n_ack <= n_ack + 1;
    end
////////////////////////////////////////////////////////////////////////////////
  task tick;
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (failures == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Idle cycle before each strobe so no strobe is lowered and raised at once
  task wr(input [7:0] a, input [31:0] v);
    begin
      tick;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input v);
    begin
      tick;
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      d = reg_rdata;
      chk({31'h0, reg_rvalid}, {31'h0, v});
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      rd(a, 1'b1);
      chk(d, exp);
    end
  endtask
  task st_end(input [31:0] s);
    begin
      tick;
      selftest_sig = s;
      selftest_end = 1'b1;
      tick;
      selftest_end = 1'b0;
    end
  endtask
  task run_wait;
    begin
      d = 32'h1;
      for (i = 0; i < 100 && d[0]; i = i + 1)
        rd(8'h83, 1'b1);
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    {sys_clk, rst_n, reg_wr, reg_rd, selftest_end, access_code_ok, bad_en, bad_upper} = 8'h00;
    {reg_addr, reg_wdata, selftest_sig, fault_raw, fault_mask} = 98'h0;
    {temp_in, angle_in} = 32'hfc80_4000;
    {rsq, bad_addr, slow} = {17'h1_2345, 6'h00, 4'h0};
    {failures, cmp_count, n_ack} = 96'h0;
    repeat (4) tick;
    rst_n = 1'b1;
    rdc(8'h83, 32'h0);
    rdc(8'h85, 32'h0);
    wr(8'h86, 32'h2);
    rdc(8'h86, 32'h0);
    rd(8'h84, 1'b0);
    rdc(8'ha7, 32'hfc80_4000);
    {temp_in, angle_in} = 32'h0180_bfff;
    rdc(8'ha7, 32'h0180_bfff);
    rdc(8'ha8, 32'h8765_1234);
    rdc(8'ha9, 32'hf0f0_0f0f);
    rdc(8'haa, 32'h0001_2345);
    fault_raw = 13'h1fdf;
    fault_mask = 13'h0a42;
    rdc(8'ha3, 32'h159d);
    {fault_raw, fault_mask, rsq} = {13'h1fff, 13'h1fdf, 17'h00010};
    tick;
    rdc(8'ha3, 32'h20);
    fault_mask = 13'h1fff;
    rdc(8'ha3, 32'h0);
    tick;
    access_code_ok = 1'b1;
    tick;
    access_code_ok = 1'b0;
    rdc(8'h86, 32'h2);
    wr(8'ha0, 32'h1);
    st_end(SIG_OK);
    rdc(8'h85, 32'h30);
    rdc(8'ha1, SIG_OK);
    wr(8'ha0, 32'h1);
    rdc(8'h85, 32'h0);
    st_end(~SIG_OK);
    rdc(8'h85, 32'h10);
    wr(8'ha0, 32'h80);
    tick;
    tick;
    chk({30'h0, out_hiz, manch_active}, 32'h3);
    rdc(8'ha0, 32'h80);
    wr(8'ha0, 32'h0);
    tick;
    tick;
    chk({30'h0, out_hiz, manch_active}, 32'h0);
    // Full pass run, both limits per word
    n_ack = 0;
    wr(8'h83, 32'h1);
    rdc(8'h83, 32'h19);
    run_wait;
    chk(d, 32'h08);
    chk(n_ack, 8);
    for (i = 0; i < 8; i = i + 1)
      chk({25'h0, log_a[i], log_u[i]}, i);
    // Custom origin, lower skipped, upper fails from word 2 on
    {bad_en, bad_addr, bad_upper, n_ack} = {1'b1, 6'h02, 1'b1, 32'h0};
    wr(8'h83, 32'hc5);
    run_wait;
    chk(d, 32'h1f4);
    chk(n_ack, 3);
    for (i = 0; i < 3; i = i + 1)
      chk({25'h0, log_a[i], log_u[i]}, 2 * i + 3);
    // Origin zero, upper skipped, lower fails from word 1 on
    {bad_addr, bad_upper, n_ack} = {6'h01, 1'b0, 32'h0};
    wr(8'h83, 32'h3);
    run_wait;
    chk(d, 32'h192);
    chk(n_ack, 4);
    for (i = 0; i < 4; i = i + 1)
      chk({25'h0, log_a[i], log_u[i]}, 2 * i);
    // Slow memory, repeat one word, then abort while a request waits
    {bad_en, slow, n_ack} = {1'b0, 4'h3, 32'h0};
    wr(8'h83, 32'h2141);
    repeat (20) tick;
    while (mt_req !== 1'b0) tick;
    while (mt_req !== 1'b1) tick;
    wr(8'h83, 32'h2140);
    rdc(8'h83, 32'h2140);
    for (i = 0; i < 3; i = i + 1)
      chk({25'h0, log_a[i], log_u[i]}, 4 + i % 2);
    // Reset in mid-run with the pin released and the radius flag up
    wr(8'ha0, 32'h80);
    wr(8'h83, 32'h1);
    repeat (3) tick;
    rst_n = 1'b0;
    repeat (2) tick;
    d = {19'h0, mt_req, mt_upper, mt_addr, selftest_launch, out_hiz, manch_active,
         radius_fault, reg_rvalid};
    chk(d, 32'h0);
    chk(reg_rdata, 32'h0);
    rst_n = 1'b1;
    rdc(8'h83, 32'h0);
    rdc(8'ha0, 32'h0);
    tally_and_finish;
  end
endmodule
